//--- rtl/power_pkg.sv
package power_pkg;

    localparam int unsigned NSRC = 10;

    localparam logic [4:0] OFF_CTRL   = 5'h00;
    localparam logic [4:0] OFF_CFG    = 5'h04;
    localparam logic [4:0] OFF_STATUS = 5'h08;
    localparam logic [4:0] OFF_WAKEEN = 5'h0C;
    localparam logic [4:0] OFF_PERIPH = 5'h10;

    localparam logic [3:0] CTRL_RESET   = 4'h0;
    localparam logic [5:0] CFG_RESET    = 6'h3E;
    localparam logic [9:0] WAKEEN_RESET = 10'h000;
    localparam logic [3:0] PERIPH_RESET = 4'h0;

    localparam int unsigned CFG_WDT_EN_BIT = 0;
    localparam int unsigned CFG_PS_LSB     = 1;
    localparam int unsigned CFG_OSC_LSB    = 4;
    localparam int unsigned CTRL_PS_LSB    = 1;

    localparam int unsigned SRC_T1    = 2;
    localparam int unsigned SRC_T3    = 3;
    localparam int unsigned SRC_SPEV  = 5;
    localparam int unsigned SRC_ADC   = 9;

    localparam logic [1:0] OSC_LP = 2'h0;
    localparam logic [1:0] OSC_HS = 2'h2;

    localparam int unsigned OST_TOSC     = 1024;
    localparam int unsigned TOSC_PER_CLK = 1;
    localparam logic [10:0] OST_CYCLES   = 11'(OST_TOSC * TOSC_PER_CLK);
    localparam logic [1:0]  LAST_PHASE   = 2'h3;
    localparam logic [20:0] PREFETCH_INC = 21'h000002;

    typedef enum logic [1:0] {
        ST_AWAKE  = 2'b00,
        ST_SLEEP  = 2'b01,
        ST_OST    = 2'b10,
        ST_RESUME = 2'b11
    } pstate_t;

    typedef struct packed {
        logic [4:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } avm_req_t;

    typedef struct packed {
        logic        sleep_exec;
        logic        watchdog_clear_instruction;
        logic        global_interrupt_enable;
        logic [20:0] pc;
    } core_req_t;

endpackage : power_pkg

//--- rtl/sleep_wakeup_controller.sv
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sleep_wakeup_controller
#(
    parameter logic [15:0] WDT_BASE_CYCLES = 16'd4800
)
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire power_pkg::avm_req_t   avm_req,
    output logic [31:0]                avm_readdata,
    output logic                       avm_waitrequest,
    input  wire power_pkg::core_req_t  core_req,
    input  wire logic [9:0]            int_flags,
    input  wire logic                  master_clear_pin_n,
    output logic                       osc_run,
    output logic                       instr_cycle,
    output logic                       port_hold,
    output logic                       sleep_nop,
    output logic                       resume,
    output logic                       branch_to_vector,
    output logic [20:0]                prefetch_addr,
    output logic                       device_reset,
    output logic                       wake_request
);
    import power_pkg::*;

    typedef struct packed {
        pstate_t     st;
        logic [1:0]  phase;
        logic [15:0] base;
        logic [7:0]  ps;
        logic [10:0] ost;
        logic        pd;
        logic        to;
        logic        by_int;
        logic [3:0]  ctrl;
        logic [5:0]  cfg;
        logic [9:0]  wake_en;
        logic [3:0]  periph;
        logic        done;
        logic [31:0] rdata;
        logic        no_operation;
        logic        res;
        logic        vec;
        logic        drst;
        logic [20:0] pf;
    } state_t;

    state_t state_reg;
    state_t state_next;

    logic       wdt_en;
    logic [2:0] ps_sel;
    logic [7:0] ps_last;
    logic       base_tick;
    logic       wdt_timeout;
    logic [9:0] allowed;
    logic [9:0] pending;
    logic       int_wake;
    logic       master_clear_pin;
    logic       crystal;
    logic       req;
    logic [31:0] rd;

    always_comb
    begin
        // Configuration enable forces the watchdog on; otherwise software decides.
        wdt_en = state_reg.cfg[CFG_WDT_EN_BIT] | state_reg.ctrl[0];
        // Configuration postscale codes run 1:128 down to 1:1, software codes the other way.
        if (state_reg.cfg[CFG_WDT_EN_BIT])
        begin
            ps_sel = ~state_reg.cfg[CFG_PS_LSB +: 3];
        end
        else
        begin
            ps_sel = state_reg.ctrl[CTRL_PS_LSB +: 3];
        end
        ps_last     = (8'h01 << ps_sel) - 8'h01;
        base_tick   = wdt_en && (state_reg.base == WDT_BASE_CYCLES - 16'h0001);
        wdt_timeout = base_tick && (state_reg.ps == ps_last);

        // Sources that need an on-chip clock are masked while asleep unless their periph bits are set.
        allowed = 10'h3FF;
        if (state_reg.st != ST_AWAKE)
        begin
            allowed[SRC_T1]   = state_reg.periph[0];
            allowed[SRC_T3]   = state_reg.periph[1];
            allowed[SRC_SPEV] = state_reg.periph[0] & state_reg.periph[2];
            allowed[SRC_ADC]  = state_reg.periph[3];
        end
        // Global enable plays no part in the wake decision.
        pending  = int_flags & state_reg.wake_en & allowed;
        int_wake = |pending;
        master_clear_pin     = ~master_clear_pin_n;
        crystal  = (state_reg.cfg[CFG_OSC_LSB +: 2] == OSC_HS)
                 || (state_reg.cfg[CFG_OSC_LSB +: 2] == OSC_LP);
        req      = avm_req.read | avm_req.write;
    end

    // Purely combinational so it is seen with the oscillator stopped.
    assign wake_request = (state_reg.st == ST_SLEEP)
                          && (master_clear_pin || wdt_timeout || int_wake);

    always_comb
    begin
        rd = 32'h00000000;
        case (avm_req.address)
            OFF_CTRL:   rd[3:0] = state_reg.ctrl;
            OFF_CFG:    rd[5:0] = state_reg.cfg;
            OFF_STATUS: rd[3:0] = {state_reg.by_int, state_reg.st == ST_SLEEP,
                                   state_reg.to, state_reg.pd};
            OFF_WAKEEN: rd[9:0] = state_reg.wake_en;
            OFF_PERIPH: rd[3:0] = state_reg.periph;
            default:    rd = 32'h00000000;
        endcase
    end

    always_comb
    begin
        state_next      = state_reg;
        state_next.no_operation  = 1'b0;
        state_next.res  = 1'b0;
        state_next.drst = 1'b0;

        // Bus: request held two cycles, answered on the second edge.
        state_next.done = req & ~state_reg.done;
        if (req && !state_reg.done)
        begin
            state_next.rdata = rd;
        end
        if (avm_req.write && state_reg.done)
        begin
            case (avm_req.address)
                OFF_CTRL:   state_next.ctrl    = avm_req.writedata[3:0];
                OFF_CFG:    state_next.cfg     = avm_req.writedata[5:0];
                OFF_WAKEEN: state_next.wake_en = avm_req.writedata[9:0];
                OFF_PERIPH: state_next.periph  = avm_req.writedata[3:0];
                default:    state_next.ctrl    = state_reg.ctrl;
            endcase
        end

        // Instruction phases advance only while the oscillator runs.
        if (state_reg.st != ST_SLEEP)
        begin
            state_next.phase = state_reg.phase + 2'h1;
        end

        // Watchdog runs on its own oscillator in every state.
        if (wdt_en)
        begin
            if (base_tick)
            begin
                state_next.base = 16'h0000;
                state_next.ps   = wdt_timeout ? 8'h00 : state_reg.ps + 8'h01;
            end
            else
            begin
                state_next.base = state_reg.base + 16'h0001;
            end
        end
        if (wdt_timeout)
        begin
            state_next.to = 1'b0;
        end
        if (core_req.watchdog_clear_instruction)
        begin
            state_next.base = 16'h0000;
            state_next.ps   = 8'h00;
        end

        case (state_reg.st)
            ST_AWAKE:
            begin
                if (wdt_timeout)
                begin
                    state_next.drst  = 1'b1;
                    state_next.phase = 2'h0;
                end
                else if (core_req.sleep_exec)
                begin
                    if (int_wake)
                    begin
                        state_next.no_operation = 1'b1;
                        state_next.base = state_reg.base;
                        state_next.ps   = state_reg.ps;
                    end
                    else
                    begin
                        state_next.st     = ST_SLEEP;
                        state_next.base   = 16'h0000;
                        state_next.ps     = 8'h00;
                        state_next.pd     = 1'b0;
                        state_next.to     = 1'b1;
                        state_next.by_int = 1'b0;
                        state_next.pf     = core_req.pc + PREFETCH_INC;
                    end
                end
            end
            ST_SLEEP:
            begin
                // A condition raised at entry wakes on the very next edge.
                if (master_clear_pin)
                begin
                    state_next.drst  = 1'b1;
                    state_next.st    = ST_AWAKE;
                    state_next.phase = 2'h0;
                    state_next.base  = 16'h0000;
                    state_next.ps    = 8'h00;
                end
                else if (wdt_timeout || int_wake)
                begin
                    state_next.by_int = int_wake & ~wdt_timeout;
                    state_next.ost    = 11'h000;
                    state_next.st     = crystal ? ST_OST : ST_RESUME;
                    state_next.phase  = 2'h0;
                end
            end
            ST_OST:
            begin
                state_next.ost = state_reg.ost + 11'h001;
                if (state_reg.ost == OST_CYCLES - 11'h001)
                begin
                    state_next.st    = ST_RESUME;
                    state_next.phase = 2'h0;
                end
            end
            ST_RESUME:
            begin
                if (state_reg.phase == LAST_PHASE)
                begin
                    state_next.st  = ST_AWAKE;
                    state_next.res = 1'b1;
                    state_next.vec = core_req.global_interrupt_enable & state_reg.by_int;
                end
            end
            default:
            begin
                state_next.st = ST_AWAKE;
            end
        endcase

        // A pin reset while awake also restarts the device.
        if (master_clear_pin && state_reg.st != ST_SLEEP)
        begin
            state_next.drst  = 1'b1;
            state_next.st    = ST_AWAKE;
            state_next.phase = 2'h0;
            state_next.base  = 16'h0000;
            state_next.ps    = 8'h00;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg         <= '0;
            state_reg.st      <= ST_AWAKE;
            state_reg.pd      <= 1'b1;
            state_reg.to      <= 1'b1;
            state_reg.ctrl    <= CTRL_RESET;
            state_reg.cfg     <= CFG_RESET;
            state_reg.wake_en <= WAKEEN_RESET;
            state_reg.periph  <= PERIPH_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign avm_readdata     = state_reg.rdata;
    assign avm_waitrequest  = req & ~state_reg.done;
    assign osc_run          = state_reg.st != ST_SLEEP;
    assign instr_cycle      = osc_run && (state_reg.phase == LAST_PHASE);
    assign port_hold        = state_reg.st != ST_AWAKE;
    assign sleep_nop        = state_reg.no_operation;
    assign resume           = state_reg.res;
    assign branch_to_vector = state_reg.vec;
    assign prefetch_addr    = state_reg.pf;
    assign device_reset     = state_reg.drst;

endmodule : sleep_wakeup_controller
`default_nettype wire

//--- bench/swc_props.sv
`timescale 1ns/1ps
`default_nettype none
module swc_props
    import power_pkg::*;
(
    input wire logic                 clk,
    input wire logic                 rst,
    input wire power_pkg::avm_req_t  avm_req,
    input wire logic [31:0]          avm_readdata,
    input wire logic                 avm_waitrequest,
    input wire power_pkg::core_req_t core_req,
    input wire logic [9:0]           int_flags,
    input wire logic                 master_clear_pin_n,
    input wire logic                 osc_run,
    input wire logic                 instr_cycle,
    input wire logic                 port_hold,
    input wire logic                 sleep_nop,
    input wire logic                 resume,
    input wire logic                 branch_to_vector,
    input wire logic [20:0]          prefetch_addr,
    input wire logic                 device_reset,
    input wire logic                 wake_request
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    property p_osc_off; $rose(port_hold) |-> !osc_run; endproperty
    a_osc_off: assert property (p_osc_off) else $error("clock runs in sleep");
    property p_fetch; $rose(port_hold) |-> prefetch_addr == $past(core_req.pc) + PREFETCH_INC; endproperty
    a_fetch: assert property (p_fetch) else $error("bad prefetch address");
    property p_hold; !osc_run |-> port_hold; endproperty
    a_hold: assert property (p_hold) else $error("ports released in sleep");
    property p_wake; wake_request && !osc_run |=> osc_run; endproperty
    a_wake: assert property (p_wake) else $error("no restart on wake");
    property p_clear; !osc_run && !master_clear_pin_n |=> device_reset && !resume; endproperty
    a_clear: assert property (p_clear) else $error("pin wake did not reset");
    property p_cycle; instr_cycle |=> !instr_cycle [*3]; endproperty
    a_cycle: assert property (p_cycle) else $error("cycle strobe too close");
    property p_vector; resume && !$past(core_req.global_interrupt_enable) |-> !branch_to_vector; endproperty
    a_vector: assert property (p_vector) else $error("vector without global enable");
    // Counts the cycles from restart of the oscillator until execution resumes.
    logic [10:0] wake_cnt;
    always_ff @(posedge clk)
    begin
        if (rst || !port_hold || resume)
        begin
            wake_cnt <= 11'h000;
        end
        else if (osc_run && wake_cnt != 11'h7FF)
        begin
            wake_cnt <= wake_cnt + 11'h001;
        end
    end
    property p_restart; $rose(osc_run) && !device_reset |-> !resume [*3]; endproperty
    a_restart: assert property (p_restart) else $error("resume timing off");
    property p_restart_max; wake_cnt <= 11'h410; endproperty
    a_restart_max: assert property (p_restart_max) else $error("resume came too late");
endmodule : swc_props
bind sleep_wakeup_controller swc_props props_u (.clk(clk), .rst(rst), .avm_req(avm_req),
    .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest), .core_req(core_req), .int_flags(int_flags),
    .master_clear_pin_n(master_clear_pin_n), .osc_run(osc_run), .instr_cycle(instr_cycle), .port_hold(port_hold),
    .sleep_nop(sleep_nop), .resume(resume), .branch_to_vector(branch_to_vector), .prefetch_addr(prefetch_addr),
    .device_reset(device_reset), .wake_request(wake_request));
`default_nettype wire

//--- bench/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model
    import power_pkg::*;
(
    input wire logic             clk,
    output power_pkg::core_req_t core_req,
    output logic [9:0]           int_flags,
    output logic                 master_clear_pin_n
);
    initial
    begin
        core_req = '0;
        int_flags = '0;
        master_clear_pin_n = 1'h1;
    end
    task automatic enter_sleep(input logic [20:0] pc, input logic global_interrupt_enable);
        @(posedge clk);
        core_req <= '{sleep_exec: 1'h0, watchdog_clear_instruction: 1'h1, global_interrupt_enable: global_interrupt_enable, pc: pc};
        @(posedge clk);
        core_req.watchdog_clear_instruction <= 1'h0;
        core_req.sleep_exec <= 1'h1;
        @(posedge clk);
        core_req.sleep_exec <= 1'h0;
    endtask : enter_sleep
    task automatic flag(input int i, input logic v);
        @(posedge clk);
        int_flags[i] <= v;
    endtask : flag
    task automatic pin_reset;
        @(posedge clk);
        master_clear_pin_n <= 1'h0;
        @(posedge clk);
        master_clear_pin_n <= 1'h1;
    endtask : pin_reset
endmodule : core_model
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import power_pkg::*;
    logic        clk, rst, avm_waitrequest, master_clear_pin_n, global_interrupt_enable;
    logic        osc_run, instr_cycle, port_hold, sleep_nop, resume, branch_to_vector, device_reset, wake_request;
    avm_req_t    avm_req;
    core_req_t   core_req;
    logic [31:0] avm_readdata, q;
    logic [9:0]  int_flags;
    logic [20:0] prefetch_addr, pc;
    logic [3:0]  p;
    int          fails, checked, n;
    initial
    begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    sleep_wakeup_controller #(.WDT_BASE_CYCLES(16'h0008)) dut_u (.clk(clk), .rst(rst), .avm_req(avm_req),
        .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest), .core_req(core_req), .int_flags(int_flags),
        .master_clear_pin_n(master_clear_pin_n), .osc_run(osc_run), .instr_cycle(instr_cycle), .port_hold(port_hold),
        .sleep_nop(sleep_nop), .resume(resume), .branch_to_vector(branch_to_vector), .prefetch_addr(prefetch_addr),
        .device_reset(device_reset), .wake_request(wake_request));
    core_model core_u (.clk(clk), .core_req(core_req), .int_flags(int_flags), .master_clear_pin_n(master_clear_pin_n));
    task automatic stop_test;
        $display("fails %0d checked %0d", fails, checked);
        if (fails == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        logic w;
        int   k;
        @(posedge clk);
        avm_req <= '{address: a, read: !wr, write: wr, writedata: d};
        k = 0;
        do
        begin
            @(posedge clk);
            w = avm_waitrequest;
            q = avm_readdata;
            k++;
        end
        while (w !== 1'h0 && k < 50);
        avm_req <= '0;
        if (w !== 1'h0)
        begin
            fails++;
            stop_test();
        end
    endtask : bus
    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
        bus(1'h0, a, 32'h0);
        chk("read data", e & m, q & m);
    endtask : rd
    task automatic wait_evt(input logic rst_evt, output int k);
        k = 0;
        do
        begin
            @(negedge clk);
            k++;
        end
        while ((rst_evt ? device_reset : resume) !== 1'h1 && k < 2000);
        if (k >= 2000)
        begin
            fails++;
            stop_test();
        end
    endtask : wait_evt
    function automatic logic [31:0] status_exp(input logic pwr_dn, input logic tmo, input logic by_int);
        return {28'h0, by_int, 1'h0, tmo, pwr_dn};
    endfunction : status_exp
    function automatic logic wakes(input int s, input logic [3:0] a);
        return s == SRC_T1 ? a[0] : s == SRC_T3 ? a[1] : s == SRC_SPEV ? a[0] & a[2] : s == SRC_ADC ? a[3] : 1'h1;
    endfunction : wakes
    function automatic logic lat_ok(input logic crystal, input int k);
        int e;
        e = 5 + (crystal ? int'(OST_CYCLES) : 0);
        return k >= e && k <= e + 1;
    endfunction : lat_ok
    initial
    begin
        fails = 0;
        checked = 0;
        rst = 1'h1;
        avm_req = '0;
        void'($urandom(3));
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        rd(OFF_STATUS, status_exp(1'h1, 1'h1, 1'h0), 32'hF);
        rd(OFF_CTRL, 32'(CTRL_RESET), 32'hFFFFFFFF);
        rd(OFF_CFG, 32'(CFG_RESET), 32'hFFFFFFFF);
        rd(OFF_WAKEEN, 32'(WAKEEN_RESET), 32'hFFFFFFFF);
        rd(OFF_PERIPH, 32'(PERIPH_RESET), 32'hFFFFFFFF);
        rd(5'h14, 32'h0, 32'hFFFFFFFF);
        bus(1'h1, OFF_STATUS, 32'h0);
        // A flag pending before sleep turns it into a no-op with flags untouched.
        bus(1'h1, OFF_WAKEEN, 32'h3FF);
        core_u.flag(1, 1'h1);
        core_u.enter_sleep(21'h000100, 1'h0);
        @(negedge clk);
        chk("sleep_nop", 1'h1, sleep_nop);
        core_u.flag(1, 1'h0);
        rd(OFF_STATUS, status_exp(1'h1, 1'h1, 1'h0), 32'hF);
        for (int s = 0; s < NSRC; s++)
        begin
            p = 4'($urandom);
            pc = 21'($urandom);
            global_interrupt_enable = 1'($urandom);
            bus(1'h1, OFF_PERIPH, {28'h0, p});
            bus(1'h1, OFF_WAKEEN, 32'h1 << s);
            core_u.flag((s + 5) % NSRC, 1'h1);
            core_u.enter_sleep(pc, global_interrupt_enable);
            @(negedge clk);
            chk("osc_run", 1'h0, osc_run);
            chk("port_hold", 1'h1, port_hold);
            chk("prefetch_addr", pc + PREFETCH_INC, prefetch_addr);
            core_u.flag(s, 1'h1);
            if (wakes(s, p))
            begin
                wait_evt(1'h0, n);
                chk("wake latency", 1'h1, lat_ok(1'h0, n));
                chk("branch_to_vector", global_interrupt_enable, branch_to_vector);
                rd(OFF_STATUS, status_exp(1'h0, 1'h1, 1'h1), 32'hF);
            end
            else
            begin
                repeat (12) @(negedge clk);
                chk("osc_run gated", 1'h0, osc_run);
                core_u.pin_reset();
                wait_evt(1'h1, n);
                rd(OFF_STATUS, status_exp(1'h0, 1'h1, 1'h0), 32'h7);
            end
            core_u.flag(s, 1'h0);
            core_u.flag((s + 5) % NSRC, 1'h0);
        end
        for (int m = 0; m < 3; m++)
        begin
            bus(1'h1, OFF_CFG, {26'h0, m == 0 ? OSC_HS : m == 1 ? OSC_LP : 2'h1, 4'hE});
            bus(1'h1, OFF_WAKEEN, 32'h1);
            core_u.enter_sleep(21'($urandom), 1'h1);
            core_u.flag(0, 1'h1);
            wait_evt(1'h0, n);
            chk("wake latency", 1'h1, lat_ok(m < 2, n));
            core_u.flag(0, 1'h0);
        end
        for (int k = 0; k < 2; k++)
        begin
            bus(1'h1, k == 0 ? OFF_CTRL : OFF_CFG, k == 0 ? 32'h1 : 32'h3F);
            wait_evt(1'h1, n);
            core_u.enter_sleep(21'h000040, 1'h1);
            wait_evt(1'h0, n);
            chk("branch_to_vector", 1'h0, branch_to_vector);
            rd(OFF_STATUS, status_exp(1'h0, 1'h0, 1'h0), 32'hF);
            bus(1'h1, OFF_CTRL, 32'h0);
            bus(1'h1, OFF_CFG, 32'h3E);
        end
        stop_test();
    end
endmodule : tb
`default_nettype wire
